/* File: hw/sld_pkg.sv */
// constants and types shared by the segment display driver
`default_nettype none
package sld_pkg;
	// clock and sub-oscillator rates
	localparam int unsigned SLD_CLK_HZ = 250000000;
	localparam int unsigned SLD_FS_HZ = 32768;
	// sub-oscillator tick spacing in system clocks, rounded down
	localparam int unsigned SLD_FS_DIV = SLD_CLK_HZ / SLD_FS_HZ;

	localparam int unsigned SLD_SEGS = 32;
	localparam int unsigned SLD_COMS = 4;

	// register byte offsets
	localparam logic [7:0] SLD_OFF_CTRL = 8'h00;
	localparam logic [7:0] SLD_OFF_ADDR = 8'h04;
	localparam logic [7:0] SLD_OFF_DATA = 8'h08;
	localparam logic [7:0] SLD_OFF_BOOST = 8'h0C;

	// display_control field positions
	localparam int unsigned SLD_CTRL_BIAS = 7;
	localparam int unsigned SLD_CTRL_DUTY_HI = 6;
	localparam int unsigned SLD_CTRL_DUTY_LO = 5;
	localparam int unsigned SLD_CTRL_EN = 4;
	localparam int unsigned SLD_CTRL_STYLE = 2;
	localparam int unsigned SLD_CTRL_FR_HI = 1;
	localparam int unsigned SLD_CTRL_FR_LO = 0;
	localparam logic [7:0] SLD_CTRL_MASK = 8'hF7;

	// system_booster_pll_control field positions
	localparam int unsigned SLD_BOOST_HI = 2;
	localparam int unsigned SLD_BOOST_LO = 1;

	// reset values
	localparam logic [7:0] SLD_CTRL_RST = 8'h00;
	localparam logic [4:0] SLD_ADDR_RST = 5'h00;
	localparam logic [1:0] SLD_BOOST_RST = 2'h0;

	// drive level codes, step index of the bias ladder
	typedef logic [1:0] sld_level_t;
	localparam sld_level_t SLD_LV_GND = 2'h0;
	localparam sld_level_t SLD_LV_LO = 2'h1;
	localparam sld_level_t SLD_LV_HI = 2'h2;
	localparam sld_level_t SLD_LV_TOP = 2'h3;

	// common period in sub-oscillator cycles, indexed by frame-rate code
	localparam logic [8:0] SLD_PER_D2 [4] = '{9'h100, 9'h118, 9'h130, 9'h0E8};
	localparam logic [8:0] SLD_PER_D3 [4] = '{9'h0AC, 9'h0BC, 9'h0CC, 9'h09C};
	localparam logic [8:0] SLD_PER_D4 [4] = '{9'h080, 9'h08C, 9'h098, 9'h074};

	// active commons per duty
	localparam logic [2:0] SLD_NCOM_D2 = 3'h2;
	localparam logic [2:0] SLD_NCOM_D3 = 3'h3;
	localparam logic [2:0] SLD_NCOM_D4 = 3'h4;

	// booster divide minus one, indexed by divider code
	localparam logic [3:0] SLD_BST_DIVM1 [4] = '{4'h0, 4'h3, 4'h7, 4'hF};
endpackage
`default_nettype wire

/* File: hw/sld_frame_timer.sv */
// common slot and polarity sequencer running on sub-oscillator ticks
`default_nettype none
module sld_frame_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fs_tick_i,
	input wire logic enable_i,
	input wire logic [8:0] period_i,
	input wire logic [2:0] ncom_i,
	input wire logic style_b_i,
	output logic [1:0] com_idx_o,
	output logic pol_o
);
	logic [8:0] cnt_q;
	logic half_q;
	logic [8:0] limit_w;
	logic end_w;
	logic adv_w;
	logic wrap_w;

	// a-style splits each slot in two halves of opposite polarity
	assign limit_w = style_b_i ? (period_i - 9'h001) : ({1'b0, period_i[8:1]} - 9'h001);
	assign end_w = fs_tick_i && enable_i && (cnt_q >= limit_w);
	assign adv_w = end_w && (style_b_i || half_q);
	assign wrap_w = ({1'b0, com_idx_o} >= (ncom_i - 3'h1));

	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			cnt_q <= 9'h000;
		end else if (fs_tick_i) begin
			cnt_q <= end_w ? 9'h000 : cnt_q + 9'h001;
		end
	end

	// commons cycle over the duty count
	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			com_idx_o <= 2'h0;
		end else if (adv_w) begin
			com_idx_o <= wrap_w ? 2'h0 : com_idx_o + 2'h1;
		end
	end

	// a-style flips per half slot, b-style per frame
	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			half_q <= 1'b0;
			pol_o <= 1'b0;
		end else if (end_w) begin
			half_q <= style_b_i ? 1'b0 : !half_q;
			if (!style_b_i || wrap_w) begin
				pol_o <= !pol_o;
			end
		end
	end

	// helper logic for the period check
	logic [8:0] ticks_q;
	logic settled_q;
	logic [8:0] per_prev_q;
	logic style_prev_q;
	always_ff @(posedge clk_i) begin
		per_prev_q <= period_i;
		style_prev_q <= style_b_i;
		if (rst_i || !enable_i || adv_w) begin
			ticks_q <= 9'h000;
		end else if (fs_tick_i) begin
			ticks_q <= ticks_q + 9'h001;
		end
		if (rst_i || !enable_i || per_prev_q != period_i || style_prev_q != style_b_i) begin
			settled_q <= 1'b0;
		end else if (adv_w) begin
			settled_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_fs_only;
		!fs_tick_i && enable_i |=> $stable(com_idx_o) && $stable(pol_o);
	endproperty
	a_fs_only: assert property (p_fs_only) else $error("slot moved without an fs tick");

	property p_period_len;
		adv_w && settled_q && (per_prev_q == period_i) |-> ticks_q == (period_i - 9'h001);
	endproperty
	a_period_len: assert property (p_period_len)
		else $error("common period length wrong");

	property p_com_range;
		adv_w |=> {1'b0, com_idx_o} < $past(ncom_i);
	endproperty
	a_com_range: assert property (p_com_range) else $error("common index beyond duty");

	property p_a_half_flip;
		end_w && !style_b_i |=> pol_o != $past(pol_o);
	endproperty
	a_a_half_flip: assert property (p_a_half_flip)
		else $error("a-style half slot kept polarity");

	property p_b_frame_flip;
		end_w && style_b_i |=> (pol_o != $past(pol_o)) == $past(wrap_w);
	endproperty
	a_b_frame_flip: assert property (p_b_frame_flip)
		else $error("b-style polarity not per frame");
endmodule
`default_nettype wire

/* File: hw/sld_driver.sv */
// segment display driver top: wishbone registers, display memory, level encoding
`default_nettype none
// How it works
// - thirty-two segment and four common lines, backed by a four by thirty-two dot memory
// - waveforms keep running in every processor operating mode
// - all slot and frame timing counts sub-oscillator ticks only
// - control bit 7 chooses half bias at zero, third bias at one
// - control bits 6..5: 00 half, 01 third, 1x quarter duty
// - control bit 4 enables; while clear every line sits at ground
// - control bit 2 chooses a-style at zero, b-style at one
// - half duty slot lasts 256, 280, 304 or 232 ticks per rate code
// - third duty 172/188/204/156, quarter duty 128/140/152/116 ticks
// - address register holds five bits, upper three read zero, selects segment 0..31
// - data register bits 3..0 move the addressed segment's dots for commons 3..0
// - booster bits 2..1 divide the sub-oscillator rate by 1, 4, 8, 16
module sld_driver #(
	parameter int unsigned FS_DIV = sld_pkg::SLD_FS_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [31:0][1:0] seg_level_o,
	output logic [3:0][1:0] com_level_o,
	output logic booster_pulse_o
);
	logic [7:0] ctrl_q;
	logic [4:0] addr_q;
	logic [1:0] boost_q;
	logic [31:0][3:0] ram_q;
	logic [15:0] fs_cnt_q;
	logic fs_tick_q;
	logic [3:0] bst_cnt_q;

	logic req_w;
	logic wr_w;
	logic [7:0] off_w;
	logic hit_ctrl_w;
	logic hit_addr_w;
	logic hit_data_w;
	logic hit_boost_w;

	// bus decode; a request is taken once, in the cycle before ack
	assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_w = req_w && wb_we_i && wb_sel_i[0];
	assign off_w = {wb_adr_i[7:2], 2'b00};
	assign hit_ctrl_w = (off_w == sld_pkg::SLD_OFF_CTRL);
	assign hit_addr_w = (off_w == sld_pkg::SLD_OFF_ADDR);
	assign hit_data_w = (off_w == sld_pkg::SLD_OFF_DATA);
	assign hit_boost_w = (off_w == sld_pkg::SLD_OFF_BOOST);

	// every request is answered one cycle later, unmapped ones too
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req_w;
		end
	end

	// unmapped offsets read zero; unused and reserved bits read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req_w) begin
			if (hit_ctrl_w) begin
				wb_dat_o <= {24'h00_0000, ctrl_q};
			end else if (hit_addr_w) begin
				wb_dat_o <= {27'h000_0000, addr_q};
			end else if (hit_data_w) begin
				wb_dat_o <= {28'h000_0000, ram_q[addr_q]};
			end else if (hit_boost_w) begin
				wb_dat_o <= {29'h0000_0000, boost_q, 1'b0};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= sld_pkg::SLD_CTRL_RST;
		end else if (wr_w && hit_ctrl_w) begin
			ctrl_q <= wb_dat_i[7:0] & sld_pkg::SLD_CTRL_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_q <= sld_pkg::SLD_ADDR_RST;
		end else if (wr_w && hit_addr_w) begin
			addr_q <= wb_dat_i[4:0];
		end
	end

	// only the booster divider bits live here; the rest of that register is elsewhere
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boost_q <= sld_pkg::SLD_BOOST_RST;
		end else if (wr_w && hit_boost_w) begin
			boost_q <= wb_dat_i[sld_pkg::SLD_BOOST_HI:sld_pkg::SLD_BOOST_LO];
		end
	end

	// display memory, one nibble per segment
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram_q <= '0;
		end else if (wr_w && hit_data_w) begin
			ram_q[addr_q] <= wb_dat_i[3:0];
		end
	end

	// sub-oscillator tick from the system clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fs_cnt_q <= 16'h0000;
			fs_tick_q <= 1'b0;
		end else if (fs_cnt_q >= 16'(FS_DIV - 1)) begin
			fs_cnt_q <= 16'h0000;
			fs_tick_q <= 1'b1;
		end else begin
			fs_cnt_q <= fs_cnt_q + 16'h0001;
			fs_tick_q <= 1'b0;
		end
	end

	// booster pulse at the divided tick rate
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bst_cnt_q <= 4'h0;
			booster_pulse_o <= 1'b0;
		end else if (fs_tick_q && bst_cnt_q >= sld_pkg::SLD_BST_DIVM1[boost_q]) begin
			bst_cnt_q <= 4'h0;
			booster_pulse_o <= 1'b1;
		end else begin
			if (fs_tick_q) begin
				bst_cnt_q <= bst_cnt_q + 4'h1;
			end
			booster_pulse_o <= 1'b0;
		end
	end

	logic en_w;
	logic third_w;
	logic style_b_w;
	logic [1:0] rate_w;
	logic [2:0] ncom_w;
	logic [8:0] period_w;
	logic [1:0] com_idx_w;
	logic pol_w;

	assign en_w = ctrl_q[sld_pkg::SLD_CTRL_EN];
	assign third_w = ctrl_q[sld_pkg::SLD_CTRL_BIAS];
	assign style_b_w = ctrl_q[sld_pkg::SLD_CTRL_STYLE];
	assign rate_w = ctrl_q[sld_pkg::SLD_CTRL_FR_HI:sld_pkg::SLD_CTRL_FR_LO];

	// duty decode, low bit ignored at quarter duty
	always_comb begin
		if (ctrl_q[sld_pkg::SLD_CTRL_DUTY_HI]) begin
			ncom_w = sld_pkg::SLD_NCOM_D4;
			period_w = sld_pkg::SLD_PER_D4[rate_w];
		end else if (ctrl_q[sld_pkg::SLD_CTRL_DUTY_LO]) begin
			ncom_w = sld_pkg::SLD_NCOM_D3;
			period_w = sld_pkg::SLD_PER_D3[rate_w];
		end else begin
			ncom_w = sld_pkg::SLD_NCOM_D2;
			period_w = sld_pkg::SLD_PER_D2[rate_w];
		end
	end

	// no mode input: timing never stops for processor power modes
	sld_frame_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.fs_tick_i(fs_tick_q),
		.enable_i(en_w),
		.period_i(period_w),
		.ncom_i(ncom_w),
		.style_b_i(style_b_w),
		.com_idx_o(com_idx_w),
		.pol_o(pol_w)
	);

	// selected common swings rail to rail; lit segments answer in opposite phase
	sld_pkg::sld_level_t sel_lv_w;
	sld_pkg::sld_level_t on_lv_w;
	sld_pkg::sld_level_t off_lv_w;
	sld_pkg::sld_level_t idle_com_lv_w;

	// level scheme per bias and polarity
	always_comb begin
		sel_lv_w = pol_w ? sld_pkg::SLD_LV_TOP : sld_pkg::SLD_LV_GND;
		on_lv_w = pol_w ? sld_pkg::SLD_LV_GND : sld_pkg::SLD_LV_TOP;
		if (third_w) begin
			off_lv_w = pol_w ? sld_pkg::SLD_LV_HI : sld_pkg::SLD_LV_LO;
			idle_com_lv_w = pol_w ? sld_pkg::SLD_LV_LO : sld_pkg::SLD_LV_HI;
		end else begin
			// half bias: off segments follow the selected common, idle commons sit mid
			off_lv_w = sel_lv_w;
			idle_com_lv_w = sld_pkg::SLD_LV_LO;
		end
	end

	for (genvar s = 0; s < sld_pkg::SLD_SEGS; s++) begin : g_seg
		always_ff @(posedge clk_i) begin
			if (rst_i || !en_w) begin
				seg_level_o[s] <= sld_pkg::SLD_LV_GND;
			end else begin
				seg_level_o[s] <= ram_q[s][com_idx_w] ? on_lv_w : off_lv_w;
			end
		end
	end

	// commons above the duty count are never selected and stay at the idle level
	for (genvar c = 0; c < sld_pkg::SLD_COMS; c++) begin : g_com
		always_ff @(posedge clk_i) begin
			if (rst_i || !en_w) begin
				com_level_o[c] <= sld_pkg::SLD_LV_GND;
			end else begin
				com_level_o[c] <= (com_idx_w == 2'(c)) ? sel_lv_w : idle_com_lv_w;
			end
		end
	end

	// helper logic for the checks below
	logic rd_addr_q;
	logic hi_seen_w;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_addr_q <= 1'b0;
		end else begin
			rd_addr_q <= req_w && !wb_we_i && hit_addr_w;
		end
	end
	always_comb begin
		hi_seen_w = 1'b0;
		for (int i = 0; i < sld_pkg::SLD_SEGS; i++) begin
			hi_seen_w = hi_seen_w || (seg_level_o[i] == sld_pkg::SLD_LV_HI);
		end
		for (int j = 0; j < sld_pkg::SLD_COMS; j++) begin
			hi_seen_w = hi_seen_w || (com_level_o[j] == sld_pkg::SLD_LV_HI);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_disabled_gnd;
		!en_w |=> (seg_level_o == '0) && (com_level_o == '0);
	endproperty
	a_disabled_gnd: assert property (p_disabled_gnd)
		else $error("disabled lines not grounded");

	property p_addr_read_zero;
		wb_ack_o && rd_addr_q |-> wb_dat_o[31:5] == 27'h000_0000;
	endproperty
	a_addr_read_zero: assert property (p_addr_read_zero)
		else $error("address upper bits not zero");

	sequence s_data_write;
		wr_w && hit_data_w ##1 wb_ack_o;
	endsequence
	property p_data_store;
		s_data_write |-> ram_q[$past(addr_q)] == $past(wb_dat_i[3:0]);
	endproperty
	a_data_store: assert property (p_data_store) else $error("dot nibble not stored");

	property p_half_bias_levels;
		!$past(third_w) && $past(en_w) |-> !hi_seen_w;
	endproperty
	a_half_bias_levels: assert property (p_half_bias_levels)
		else $error("third-bias level in half bias");

	property p_seg_on;
		$past(en_w) && $past(ram_q[0][com_idx_w]) |-> seg_level_o[0] == $past(on_lv_w);
	endproperty
	a_seg_on: assert property (p_seg_on) else $error("lit segment level wrong");

	property p_com_select;
		$past(en_w) |-> com_level_o[$past(com_idx_w)] == ($past(pol_w) ? 2'h3 : 2'h0);
	endproperty
	a_com_select: assert property (p_com_select)
		else $error("selected common not at a rail");

	property p_booster_div1;
		boost_q == 2'h0 && fs_tick_q |=> booster_pulse_o;
	endproperty
	a_booster_div1: assert property (p_booster_div1)
		else $error("booster missed undivided tick");

	property p_booster_on_tick;
		booster_pulse_o |-> $past(fs_tick_q);
	endproperty
	a_booster_on_tick: assert property (p_booster_on_tick)
		else $error("booster pulse off tick");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");

	property p_ack_answers;
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_answers: assert property (p_ack_answers) else $error("ack without a request");

	property p_ctrl_write;
		wr_w && hit_ctrl_w |=> ctrl_q[7:4] == $past(wb_dat_i[7:4]) && !ctrl_q[3];
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control not stored");

	property p_addr_write;
		wr_w && hit_addr_w |=> addr_q == $past(wb_dat_i[4:0]);
	endproperty
	a_addr_write: assert property (p_addr_write) else $error("address not stored");

	property p_boost_write;
		wr_w && hit_boost_w |=> boost_q == $past(wb_dat_i[2:1]);
	endproperty
	a_boost_write: assert property (p_boost_write) else $error("divider not stored");

	property p_third_dark;
		$past(en_w) && $past(third_w) && !$past(ram_q[0][com_idx_w])
			|-> seg_level_o[0] == ($past(pol_w) ? 2'h2 : 2'h1);
	endproperty
	a_third_dark: assert property (p_third_dark)
		else $error("third-bias dark segment not on a step");

	property p_half_dark;
		$past(en_w) && !$past(third_w) && !$past(ram_q[0][com_idx_w])
			|-> seg_level_o[0] == com_level_o[$past(com_idx_w)];
	endproperty
	a_half_dark: assert property (p_half_dark)
		else $error("half-bias dark segment not at common");
endmodule
`default_nettype wire

/* File: sim/sld_panel_model.sv */
// glass model: flags every dot whose segment and common sit on opposite rails
`default_nettype none
module sld_panel_model (
	input wire logic [31:0][1:0] seg_level_i,
	input wire logic [3:0][1:0] com_level_i,
	output logic [3:0][31:0] full_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// only a full-rail difference turns a dot on; bias steps stay below threshold
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 32; s++) begin
				full_o[c][s] = ((seg_level_i[s] ^ com_level_i[c]) == 2'h3)
					&& (seg_level_i[s][0] == seg_level_i[s][1]);
			end
		end
	end
endmodule
`default_nettype wire

/* File: sim/sld_driver_tb.sv */
// self-checking bench for the segment display driver
`default_nettype none
module sld_driver_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// short tick keeps every slot between 464 and 1216 clocks
	localparam int unsigned FSD = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [31:0][1:0] seg_level_o;
	logic [3:0][1:0] com_level_o;
	logic booster_pulse_o;
	logic [3:0][31:0] full;
	logic [3:0] mem [32];
	logic [31:0] rd;
	int error_cnt = 0;
	int compares = 0;
	int cyc_cnt = 0;
	always #2 clk_i = ~clk_i;
	sld_driver #(.FS_DIV(FSD)) u_sld_driver (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.seg_level_o(seg_level_o), .com_level_o(com_level_o),
		.booster_pulse_o(booster_pulse_o));
	sld_panel_model u_sld_panel_model (.seg_level_i(seg_level_o),
		.com_level_i(com_level_o), .full_o(full));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// hang guard: the display sweep dominates at about 23k clocks
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
		input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= {24'h0, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50) chk("ack", 32'h0, 32'h1);
	endtask
	function automatic logic [31:0] reg_exp(input int j, input logic [7:0] v);
		logic [7:0] m [4] = '{8'hF7, 8'h1F, 8'h06, 8'h00};
		return {24'h0, v & m[j]};
	endfunction
	function automatic int per(input logic [7:0] c);
		int t [12] = '{256, 280, 304, 232, 172, 188, 204, 156, 128, 140, 152, 116};
		return FSD * t[(c[6] ? 8 : c[5] ? 4 : 0) + c[1:0]];
	endfunction
	function automatic logic sel_lv(input logic [1:0] lv);
		return lv === 2'h0 || lv === 2'h3;
	endfunction
	function automatic logic [31:0] lit_vec(input int k);
		logic [31:0] v;
		for (int s = 0; s < 32; s++) v[s] = mem[s][k];
		return v;
	endfunction
	function automatic logic has2();
		logic h;
		h = 1'b0;
		for (int s = 0; s < 32; s++) h = h | (seg_level_o[s] === 2'h2);
		for (int k = 0; k < 4; k++) h = h | (com_level_o[k] === 2'h2);
		return h;
	endfunction
	initial begin
		logic [7:0] offs [4];
		logic [7:0] v;
		logic [7:0] c;
		logic [1:0] lv;
		int g;
		int len;
		int fl;
		int w;
		offs = '{8'h00, 8'h04, 8'h0C, 8'h10};
		void'($urandom(94));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int j = 0; j < 4; j++) begin
			wb(1'b0, offs[j], 8'h00, 4'hF);
			chk("reset_val", rd, 32'h0); // reset and unmapped reads
		end
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			v = 8'($urandom);
			wb(1'b1, offs[i % 4], v, 4'hF);
			wb(1'b0, offs[i % 4], 8'h00, 4'hF);
			chk("reg_readback", rd, reg_exp(i % 4, v)); // masks per register
		end
		wb(1'b1, 8'h04, v & 8'h0F, 4'hF);
		wb(1'b1, 8'h04, 8'hFF, 4'hE);
		wb(1'b0, 8'h04, 8'h00, 4'hF);
		chk("sel_ignored", rd, reg_exp(1, v & 8'h0F)); // lane off keeps value
		$display("test registers done");
		for (int s = 0; s < 32; s++) begin
			mem[s] = 4'($urandom);
			wb(1'b1, 8'h04, 8'(s), 4'hF);
			wb(1'b1, 8'h08, {4'hF, mem[s]}, 4'hF);
		end
		for (int s = 31; s >= 0; s--) begin
			wb(1'b1, 8'h04, 8'(s), 4'hF);
			wb(1'b0, 8'h08, 8'h00, 4'hF);
			chk("dots", rd, {28'h0, mem[s]}); // dot transfer
		end
		$display("test memory done");
		for (int b = 0; b < 4; b++) begin
			wb(1'b1, 8'h0C, 8'(b << 1), 4'hF);
			for (int r = 0; r < 3; r++) begin
				g = 0;
				do begin
					@(posedge clk_i);
					g++;
				end while (booster_pulse_o !== 1'b1 && g < 200);
			end
			chk("boost_gap", g, FSD << (b == 0 ? 0 : b + 1)); // divider
		end
		$display("test booster done");
		for (int i = 0; i < 16; i++) begin
			wb(1'b1, 8'h00, 8'h00, 4'hF);
			repeat (3) @(posedge clk_i);
			chk("off", {31'h0, |{seg_level_o, com_level_o}}, 32'h0); // ground
			c = {i[0] ^ i[2], i[3:2], 1'b1, 1'b0, i[1] ^ i[3], i[1:0]};
			wb(1'b1, 8'h00, c, 4'hF);
			w = 0;
			do begin
				@(posedge clk_i);
				w++;
			end while (!sel_lv(com_level_o[1]) && w < 6000);
			chk("lit_map", full[1], lit_vec(1)); // dot levels
			if (!c[7]) chk("half_levels", {31'h0, has2()}, 32'h0); // half bias
			len = 0;
			fl = 0;
			lv = com_level_o[1];
			while (sel_lv(com_level_o[1]) && len < 2000) begin
				if (com_level_o[1] !== lv) fl++;
				lv = com_level_o[1];
				len++;
				@(posedge clk_i);
			end
			if (c[6:5] == 2'h0) chk("slot_half", len, per(c)); // slot length
			else chk("slot_len", len, per(c)); // slot length
			chk("style_flips", fl, c[2] ? 0 : 1); // waveform style
			chk("next_com", {31'h0, sel_lv(com_level_o[2])}, {31'h0, c[6:5] != 2'h0});
		end
		$display("test display done");
		complete_run();
	end
endmodule
`default_nettype wire
